// ---- hw/cdfa_top.sv ----
// card deactivation sequencer with presence debounce and fault alert
`timescale 1ns/1ps
module cdfa_top
  import cdfa_pkg::*;
#(
  parameter longint CLK_HZ       = CDFA_CLK_HZ,
  parameter int     DEACT_CYC    = cdfa_ns_to_cyc(CDFA_DEACT_NS, CLK_HZ),
  parameter int     DEBOUNCE_CYC = cdfa_us_to_cyc(CDFA_DEBOUNCE_US, CLK_HZ)
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // host side
  input  wire logic session_request_n,
  input  wire logic host_reset_in,
  input  wire logic card_clock_in,
  output logic      alert_n,
  // monitors and card detect
  input  wire logic presence_detect,
  input  wire logic supply_below_dropout,
  input  wire logic card_supply_overload,
  input  wire logic card_supply_out_of_range,
  input  wire logic regulator_supply_low,
  input  wire logic over_temperature,
  input  wire logic pin_current_limit,
  // card side
  output logic      card_reset_out,
  output logic      card_clock_out,
  output logic      card_supply_en,
  input  wire logic card_data_line_i,
  output logic      card_data_line_o,
  output logic      card_data_line_oe,
  input  wire logic card_aux_line_1_i,
  output logic      card_aux_line_1_o,
  output logic      card_aux_line_1_oe,
  input  wire logic card_aux_line_2_i,
  output logic      card_aux_line_2_o,
  output logic      card_aux_line_2_oe
);

  logic [CDFA_PIN_W-1:0] pin_raw;
  logic [CDFA_PIN_W-1:0] pin_s;
  logic                  sess_n_s;
  logic                  sess_prev_q;
  logic                  sess_fall;
  logic                  presence_detect_s;
  logic                  presence_detect_prev_q;
  logic                  card_present_q;
  logic                  vdd_low_s;
  logic                  fault_any;
  logic                  fault_q;
  logic                  deb_start;
  logic                  deb_busy;
  logic                  deb_done;
  logic                  dly_start;
  logic                  dly_done;
  logic                  lines_low_d;
  cdfa_state_e           state_q;
  cdfa_state_e           state_d;

  // all host, monitor and card detect pin inputs cross into the clock domain together
  assign pin_raw = {pin_current_limit, over_temperature, regulator_supply_low,
                    card_supply_out_of_range, card_supply_overload,
                    supply_below_dropout, card_clock_in, presence_detect,
                    host_reset_in, session_request_n};

  cdfa_sync #(
    .W       (CDFA_PIN_W),
    .RST_VAL (CDFA_PIN_RST)
  ) u_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_in    (pin_raw),
    .level_out (pin_s)
  );

  assign sess_n_s  = pin_s[CDFA_B_SESS_N];
  assign presence_detect_s    = pin_s[CDFA_B_PRESENCE_DETECT];
  assign vdd_low_s = pin_s[CDFA_B_VDDLOW];

  // edge history of session request and synchronised presence
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sess_prev_q <= 1'b1;
      presence_detect_prev_q <= 1'b0;
    end else begin
      sess_prev_q <= sess_n_s;
      presence_detect_prev_q <= presence_detect_s;
    end
  end

  assign sess_fall = sess_prev_q && !sess_n_s;

  // insertion debounce: restarts on each rising edge, dropped on bounce
  assign deb_start = presence_detect_s && !presence_detect_prev_q;

  cdfa_timer #(
    .COUNT (DEBOUNCE_CYC)
  ) u_debounce (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (deb_start),
    .abort   (!presence_detect_s),
    .busy    (deb_busy),
    .done    (deb_done)
  );

  // presence flag: set only when debounce ends, cleared at once on removal
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      card_present_q <= 1'b0; // R13
    end else if (!presence_detect_s) begin
      card_present_q <= 1'b0; // R10
    end else if (deb_done) begin
      card_present_q <= 1'b1; // R9
    end
  end

  // fault sources; pin current limiting is left out on purpose
  assign fault_any = !card_present_q || vdd_low_s || pin_s[CDFA_B_OVLD] // R11
                  || pin_s[CDFA_B_RANGE] || pin_s[CDFA_B_REGLOW]
                  || pin_s[CDFA_B_HOT]; // R12

  // fault latch: set in a session, cleared once host has released the request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (state_q == ST_ACTIVE && fault_any) begin
      fault_q <= 1'b1; // R7
    end else if (state_q == ST_IDLE && sess_n_s) begin
      fault_q <= 1'b0; // R8
    end
  end

  // reset-to-clock-stop delay starts as reset is forced low
  assign dly_start = (state_q == ST_ACTIVE) && (state_d == ST_D_RST);

  cdfa_timer #(
    .COUNT (DEACT_CYC)
  ) u_deact_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (dly_start),
    .abort   (1'b0),
    .busy    (),
    .done    (dly_done) // R16
  );

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (sess_fall && !fault_any) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sess_n_s || fault_any) begin
          state_d = ST_D_RST; // R1 R7 R10
        end
      end
      ST_D_RST: begin
        if (dly_done) begin
          state_d = ST_D_CLK; // R2
        end
      end
      ST_D_CLK: begin
        state_d = ST_D_IO; // R3
      end
      ST_D_IO: begin
        state_d = ST_D_OFF; // R3
      end
      ST_D_OFF: begin
        if (sess_n_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // card reset follows host reset only while a session runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      card_reset_out <= 1'b0;
    end else begin
      card_reset_out <= (state_d == ST_ACTIVE) && pin_s[CDFA_B_HRST]; // R1 R15
    end
  end

  // card clock passes until the stop delay has run out
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      card_clock_out <= 1'b0;
    end else begin
      card_clock_out <= (state_d == ST_ACTIVE || state_d == ST_D_RST)
                        && pin_s[CDFA_B_CLKIN]; // R2
    end
  end

  // data and aux lines pulled low from the step after clock stop
  assign lines_low_d = !(state_d == ST_ACTIVE || state_d == ST_D_RST
                         || state_d == ST_D_CLK);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      card_data_line_oe  <= 1'b1;
      card_aux_line_1_oe <= 1'b1;
      card_aux_line_2_oe <= 1'b1;
      card_data_line_o   <= 1'b0;
      card_aux_line_1_o  <= 1'b0;
      card_aux_line_2_o  <= 1'b0;
    end else begin
      card_data_line_oe  <= lines_low_d; // R3 R14
      card_aux_line_1_oe <= lines_low_d;
      card_aux_line_2_oe <= lines_low_d;
      card_data_line_o   <= 1'b0;
      card_aux_line_1_o  <= 1'b0;
      card_aux_line_2_o  <= 1'b0;
    end
  end

  // card supply is the last thing switched off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      card_supply_en <= 1'b0;
    end else begin
      card_supply_en <= (state_d != ST_IDLE) && (state_d != ST_D_OFF); // R3 R14
    end
  end

  // alert: low on fault, else presence gated by logic supply dropout
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alert_n <= 1'b0; // R13
    end else if (fault_q || (state_q == ST_ACTIVE && fault_any)) begin
      alert_n <= 1'b0; // R7 R10
    end else begin
      alert_n <= card_present_q && !vdd_low_s; // R5 R6 R9
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence deact_entry;
    (state_q == ST_ACTIVE) ##1 (state_q == ST_D_RST);
  endsequence

  sequence deact_tail;
    (state_q == ST_D_CLK) ##1 (state_q == ST_D_IO) ##1 (state_q == ST_D_OFF);
  endsequence

  // cycles spent with reset forced low before the clock stops
  int unsigned rst_low_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_low_cnt <= 0;
    end else if (state_q == ST_D_RST) begin
      rst_low_cnt <= rst_low_cnt + 1;
    end else begin
      rst_low_cnt <= 0;
    end
  end

  reset_first_a: assert property (deact_entry |-> !card_reset_out && card_supply_en) // R1
    else $error("card reset not forced low at deactivation start");

  clock_stop_delay_a: assert property ( // R2
    (state_q == ST_D_RST) ##1 (state_q == ST_D_CLK)
    |-> !card_clock_out && (rst_low_cnt == DEACT_CYC))
    else $error("card clock stop not at the fixed delay");

  lines_then_supply_a: assert property ( // R3
    deact_tail |-> card_data_line_oe && card_aux_line_1_oe && card_aux_line_2_oe
                   && !card_supply_en && $past(card_supply_en)
                   && $past(card_data_line_oe))
    else $error("supply cut before lines pulled low");

  idle_alert_a: assert property ( // R5
    (state_q == ST_IDLE && !fault_q) |=> alert_n == $past(card_present_q && !vdd_low_s))
    else $error("idle alert does not show presence");

  fault_deact_a: assert property ( // R7
    (state_q == ST_ACTIVE && fault_any) |=> (state_q == ST_D_RST) && !alert_n
                                            && !card_reset_out)
    else $error("fault did not start deactivation");

  debounce_end_a: assert property ($rose(card_present_q) |-> $past(deb_done) && presence_detect_s) // R9
    else $error("presence set without debounce expiry");

  removal_a: assert property ( // R10
    (state_q == ST_ACTIVE && !presence_detect_s) |=> !card_present_q ##1 !alert_n)
    else $error("card removal not handled at once");

  silent_limit_a: assert property ( // R12
    (state_q == ST_ACTIVE && pin_s[CDFA_B_ILIM] && !fault_any && !sess_n_s)
    |=> state_q == ST_ACTIVE)
    else $error("current limit caused deactivation");

  no_card_alert_a: assert property (!card_present_q [*2] |-> !alert_n) // R13
    else $error("alert high without a card");

  standby_pins_a: assert property ( // R14
    (state_q == ST_IDLE) [*2] |-> !card_supply_en && !card_reset_out && !card_clock_out
                                  && card_data_line_oe && !card_data_line_o)
    else $error("card pins active in standby");

  reset_follow_a: assert property ( // R15
    (state_q == ST_ACTIVE && state_d == ST_ACTIVE) |=> card_reset_out == $past(pin_s[CDFA_B_HRST]))
    else $error("card reset does not follow host reset");

endmodule

// ---- shared/cdfa_pkg.sv ----
// constants and types for the card deactivation and fault alert block
// Contract
// [R1] session request going high starts deactivation by forcing card reset low first
// [R2] card clock goes low a fixed 12 us after card reset is forced low
// [R3] after clock stop, data and aux lines go low, then card supply switches off
// [R4] host keeps session request high when idle, opens a session by driving it low
// [R5] outside a session alert is low without a card and high with one
// [R6] card present, idle: alert low on logic supply dropout, high on recovery
// [R7] fault during a session drives alert low and starts deactivation at once
// [R8] after a fault host raises session request, waits, then samples alert again
// [R9] insertion runs an 8 ms debounce; alert rises only when it expires
// [R10] card removal deactivates at once and drives alert low
// [R11] faults: extraction, logic undervoltage, supply overload, supply range, regulator low, heat
// [R12] pin current limiting never pulls alert low and never deactivates
// [R13] after power-up alert stays low until a card is inserted
// [R14] in standby all card-side pins are inactive and held low
// [R15] in a session card reset follows host reset until deactivation forces it low
// [R16] delays are counters on the input clock, counts derived from clock frequency
package cdfa_pkg;

  // clock and printed times
  localparam longint CDFA_CLK_HZ      = 100_000_000;
  localparam longint CDFA_DEACT_NS    = 12_000;
  localparam longint CDFA_DEBOUNCE_US = 8_000;

  // a least time rounds up to whole cycles
  function automatic int cdfa_ns_to_cyc(input longint ns, input longint hz);
    longint c;
    c = (ns * hz + 64'd999_999_999) / 64'd1_000_000_000;
    return (c < 1) ? 1 : int'(c);
  endfunction

  // a typical time rounds down, never under one cycle
  function automatic int cdfa_us_to_cyc(input longint us, input longint hz);
    longint c;
    c = (us * hz) / 64'd1_000_000;
    return (c < 1) ? 1 : int'(c);
  endfunction

  localparam int CDFA_DEACT_CYC    = cdfa_ns_to_cyc(CDFA_DEACT_NS, CDFA_CLK_HZ);
  localparam int CDFA_DEBOUNCE_CYC = cdfa_us_to_cyc(CDFA_DEBOUNCE_US, CDFA_CLK_HZ);

  // bit positions of the synchronised pin vector
  localparam int CDFA_PIN_W     = 10;
  localparam int CDFA_B_SESS_N  = 0;
  localparam int CDFA_B_HRST    = 1;
  localparam int CDFA_B_PRESENCE_DETECT    = 2;
  localparam int CDFA_B_CLKIN   = 3;
  localparam int CDFA_B_VDDLOW  = 4;
  localparam int CDFA_B_OVLD    = 5;
  localparam int CDFA_B_RANGE   = 6;
  localparam int CDFA_B_REGLOW  = 7;
  localparam int CDFA_B_HOT     = 8;
  localparam int CDFA_B_ILIM    = 9;

  // reset value of the pin vector: session request idles high
  localparam logic [CDFA_PIN_W-1:0] CDFA_PIN_RST = 10'h001;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_D_RST  = 3'b010,
    ST_D_CLK  = 3'b011,
    ST_D_IO   = 3'b100,
    ST_D_OFF  = 3'b101
  } cdfa_state_e;

endpackage

// ---- hw/cdfa_sync.sv ----
// three-stage synchroniser for pin inputs, change taken when stages two and three agree
`timescale 1ns/1ps
module cdfa_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // pins and clean level
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;

  // shift chain; the first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q   <= RST_VAL;
      stage2_q <= RST_VAL;
      stage3_q <= RST_VAL;
    end else begin
      meta_q   <= pin_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // each bit changes only once two stages agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_out <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          level_out[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule

// ---- hw/cdfa_timer.sv ----
// one-shot down counter: done pulses exactly COUNT cycles after start
`timescale 1ns/1ps
module cdfa_timer #(
  parameter int COUNT = 16
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // control
  input  wire logic start,
  input  wire logic abort,
  // status
  output logic      busy,
  output logic      done
);

  localparam int CW = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [CW-1:0] LOAD = CW'(COUNT - 1);

  logic [CW-1:0] cnt_q;

  // final cycle of a run
  assign done = busy && (cnt_q == '0) && !abort;

  // load on start, count down, stop on done or abort
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      busy  <= 1'b0;
    end else if (start) begin
      cnt_q <= LOAD;
      busy  <= 1'b1;
    end else if (abort || done) begin
      busy  <= 1'b0;
    end else if (busy) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

endmodule

// ---- testbench/cdfa_host_model.sv ----
// host model: drives the session request and host reset pins
`timescale 1ns/1ps
module cdfa_host_model (
  // clock
  input  wire logic clk_sys,
  // commands from the bench
  input  wire logic open_cmd,
  input  wire logic reset_cmd,
  // host pins
  output logic      session_request_n,
  output logic      host_reset_in
);
  logic open_q  = 1'h0;
  logic reset_q = 1'h1;

  // request idles high until a session is wanted
  initial begin
    session_request_n = 1'h1;
    host_reset_in     = 1'h1;
  end

  // commands taken on the rising edge, so a bench change in the same step cannot race
  always @(posedge clk_sys) begin
    open_q  <= open_cmd;
    reset_q <= reset_cmd;
  end

  // pins move on the falling edge, clear of the sampling edge
  always @(negedge clk_sys) begin
    session_request_n <= !open_q;
    host_reset_in     <= reset_q;
  end
endmodule

// ---- testbench/tb_card_deactivation_fault_alert.sv ----
// testbench for the card deactivation and fault alert block
`timescale 1ns/1ps
module tb_card_deactivation_fault_alert;
  import cdfa_pkg::*;
  localparam int DEACT_CYC    = 20;
  localparam int DEBOUNCE_CYC = 50;

  logic       clk_sys = 1'h0;
  logic       rst = 1'h1;
  logic       open_cmd = 1'h0;
  logic       reset_cmd = 1'h1;
  logic       clk_in = 1'h1;
  logic       presence = 1'h0;
  logic [4:0] fault = 5'h00;
  logic       ilim = 1'h0;
  logic       sreq_n, hrst, alert_n, card_reset_out, card_clock_out, card_supply_en;
  logic       d_o, d_oe, a1_o, a1_oe, a2_o, a2_oe;
  wire logic  d_w, a1_w, a2_w;
  int         n_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;

  // line levels: driven low by the device, otherwise pulled up
  assign d_w  = d_oe ? d_o : 1'h1;
  assign a1_w = a1_oe ? a1_o : 1'h1;
  assign a2_w = a2_oe ? a2_o : 1'h1;

  // clock and timeout
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  cdfa_host_model host (.clk_sys(clk_sys), .open_cmd(open_cmd), .reset_cmd(reset_cmd),
    .session_request_n(sreq_n), .host_reset_in(hrst));

  cdfa_top #(.DEACT_CYC(DEACT_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) uut (
    .clk_sys(clk_sys), .rst(rst), .session_request_n(sreq_n), .host_reset_in(hrst),
    .card_clock_in(clk_in), .alert_n(alert_n), .presence_detect(presence),
    .supply_below_dropout(fault[0]), .card_supply_overload(fault[1]),
    .card_supply_out_of_range(fault[2]), .regulator_supply_low(fault[3]),
    .over_temperature(fault[4]), .pin_current_limit(ilim),
    .card_reset_out(card_reset_out), .card_clock_out(card_clock_out),
    .card_supply_en(card_supply_en), .card_data_line_i(d_w), .card_data_line_o(d_o),
    .card_data_line_oe(d_oe), .card_aux_line_1_i(a1_w), .card_aux_line_1_o(a1_o),
    .card_aux_line_1_oe(a1_oe), .card_aux_line_2_i(a2_w), .card_aux_line_2_o(a2_o),
    .card_aux_line_2_oe(a2_oe));

  // verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare one bit
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // compare a cycle count
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // wait a bounded time for the alert level, then judge it
  task automatic wait_alert(input logic v, input int lim);
    int n;
    n = 0;
    while (alert_n !== v && n < lim) begin
      cyc(1);
      n++;
    end
    chk(alert_n, v);
  endtask

  // wait a bounded time for the card supply to switch off
  task automatic wait_off();
    int n;
    n = 0;
    while (card_supply_en !== 1'h0 && n < DEACT_CYC + 10) begin
      cyc(1);
      n++;
    end
    chk(card_supply_en, 1'h0);
  endtask

  // all card-side pins inactive and held low
  task automatic chk_standby();
    chk(card_reset_out, 1'h0);
    chk(card_clock_out, 1'h0);
    chk(card_supply_en, 1'h0);
    chk(d_w, 1'h0);
    chk(a1_w, 1'h0);
    chk(a2_w, 1'h0);
  endtask

  // insert a card: alert may rise only once the debounce has run out
  task automatic insert_card();
    presence = 1'h1;
    cyc(DEBOUNCE_CYC);
    chk(alert_n, 1'h0);
    wait_alert(1'h1, 12);
  endtask

  task automatic open_session();
    open_cmd = 1'h1;
    cyc(8);
    chk(card_supply_en, 1'h1);
    chk(d_oe, 1'h0);
    chk(card_reset_out, 1'h1);
  endtask

  // close a session and time each deactivation step after card reset goes low
  task automatic close_session();
    int n;
    n = 0;
    open_cmd = 1'h0;
    while (card_reset_out !== 1'h0 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(card_reset_out, 1'h0);
    chk(card_clock_out, 1'h1);
    n = 0;
    while (card_clock_out !== 1'h0 && n < DEACT_CYC + 5) begin
      cyc(1);
      n++;
    end
    chk_cnt(n, DEACT_CYC);
    chk(d_oe, 1'h0);
    chk(card_supply_en, 1'h1);
    cyc(1);
    chk(d_oe, 1'h1);
    chk(a1_oe, 1'h1);
    chk(a2_oe, 1'h1);
    chk(card_supply_en, 1'h1);
    cyc(1);
    chk(card_supply_en, 1'h0);
    cyc(6);
    chk_standby();
  endtask

  // standby after power-up and a bounced insertion
  task automatic t_standby();
    cyc(2);
    chk(alert_n, 1'h0);
    chk_standby();
    presence = 1'h1;
    cyc(20);
    presence = 1'h0;
    cyc(DEBOUNCE_CYC + 10);
    chk(alert_n, 1'h0);
    insert_card();
  endtask

  // logic supply dropout outside a session
  task automatic t_dropout();
    fault[0] = 1'h1;
    wait_alert(1'h0, 6);
    fault[0] = 1'h0;
    wait_alert(1'h1, 6);
  endtask

  // session with card reset following the host, then a normal end
  task automatic t_session();
    open_session();
    reset_cmd = 1'h0;
    clk_in    = 1'h0;
    cyc(7);
    chk(card_reset_out, 1'h0);
    chk(card_clock_out, 1'h0);
    reset_cmd = 1'h1;
    clk_in    = 1'h1;
    cyc(7);
    chk(card_reset_out, 1'h1);
    chk(card_clock_out, 1'h1);
    close_session();
    chk(alert_n, 1'h1);
  endtask

  // each monitored fault ends the session on its own
  task automatic t_faults();
    for (int i = 0; i < 5; i++) begin
      open_session();
      fault[i] = 1'h1;
      wait_alert(1'h0, 8);
      chk(card_reset_out, 1'h0);
      wait_off();
      fault[i] = 1'h0;
      open_cmd = 1'h0;
      cyc(10);
      wait_alert(1'h1, 10);
    end
  endtask

  // card pulled out in mid-session
  task automatic t_extract();
    open_session();
    presence = 1'h0;
    wait_alert(1'h0, 8);
    wait_off();
    open_cmd = 1'h0;
    cyc(10);
    chk(alert_n, 1'h0);
    chk_standby();
    insert_card();
  endtask

  // pin current limiting stays silent
  task automatic t_ilim();
    open_session();
    ilim = 1'h1;
    cyc(100);
    chk(alert_n, 1'h1);
    chk(card_supply_en, 1'h1);
    ilim = 1'h0;
    close_session();
  endtask

  // main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'h0;
    t_standby();
    t_dropout();
    t_session();
    t_faults();
    t_extract();
    t_ilim();
    wrap_up();
  end
endmodule
